// *** rtl/tcc_regs.vh ***
// register offsets, field positions and timing counts for the transmit channel controller
`ifndef TCC_REGS_VH
`define TCC_REGS_VH
`define TCC_OFF_CONFIG      8'h30
`define TCC_OFF_STATUS      8'h31
`define TCC_OFF_ADDR_CTRL   8'h32
`define TCC_OFF_DATA_BUF    8'h33
`define TCC_BIT_PCC_EN      0
`define TCC_BIT_IND_EN      1
`define TCC_BIT_BUSY        7
`define TCC_BIT_RNW         7
`define TCC_RST_BYTE        8'h00
`define TCC_TBL_FIRST       7'h01
`define TCC_TBL_LAST        7'h48
`define TCC_TBL_DEPTH       72
`define TCC_CHANNELS        24
`define TCC_IDLE_BASE       7'h19
`define TCC_SIG_BASE        7'h31
`define TCC_ACCESS_NS       640
`define TCC_CLK_NS          8
`define TCC_ACCESS_CYC      (`TCC_ACCESS_NS / `TCC_CLK_NS)
`define TCC_ACCESS_USED     8'h04
`endif

// *** rtl/tcc_table.v ***
// 72-byte per-channel table, flip-flop storage with one write and one read port
`timescale 1ns/1ns
`default_nettype none
`include "tcc_regs.vh"
module tcc_table (
   input  wire        ref_clk_i,
   input  wire        rst_n_i,
   input  wire        wr_en_i,
   input  wire [6:0]  wr_idx_i,
   input  wire [7:0]  wr_data_i,
   input  wire [6:0]  rd_idx_i,
   output reg  [7:0]  rd_data_o,
   output wire [575:0] flat_o
);
   genvar g;
   generate
      for (g = 0; g < `TCC_TBL_DEPTH; g = g + 1) begin : g_ent
         reg [7:0] ent_r;
         always @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               ent_r <= `TCC_RST_BYTE;
            end else if (wr_en_i && {25'd0, wr_idx_i} == g) begin
               ent_r <= wr_data_i;
            end
         end
         assign flat_o[g*8 +: 8] = ent_r;
      end
   endgenerate

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rd_data_o <= `TCC_RST_BYTE;
      end else if (rd_idx_i < `TCC_TBL_DEPTH) begin
         rd_data_o <= flat_o[rd_idx_i*8 +: 8];
      end else begin
         rd_data_o <= `TCC_RST_BYTE;
      end
   end
endmodule
`default_nettype wire

// *** rtl/tcc_chan_out.v ***
// selects one channel's three bytes for the basic transmitter, gated by the enable
`timescale 1ns/1ns
`default_nettype none
`include "tcc_regs.vh"
module tcc_chan_out (
   input  wire         ref_clk_i,
   input  wire         rst_n_i,
   input  wire         pcc_en_i,
   input  wire [4:0]   chan_i,
   input  wire [575:0] flat_i,
   output reg  [7:0]   pcm_ctrl_o,
   output reg  [7:0]   idle_code_o,
   output reg  [7:0]   sig_ctrl_o
);
   wire [6:0] ch = {2'b00, chan_i};
   always @(posedge ref_clk_i) begin
      if (!rst_n_i || !pcc_en_i || chan_i >= `TCC_CHANNELS) begin
         pcm_ctrl_o  <= `TCC_RST_BYTE;
         idle_code_o <= `TCC_RST_BYTE;
         sig_ctrl_o  <= `TCC_RST_BYTE;
      end else begin
         pcm_ctrl_o  <= flat_i[ch*8 +: 8];
         idle_code_o <= flat_i[(ch + 7'd24)*8 +: 8];
         sig_ctrl_o  <= flat_i[(ch + 7'd48)*8 +: 8];
      end
   end
endmodule
`default_nettype wire

// *** rtl/tcc_indirect.v ***
// transmit channel controller indirect access port on an avalon-mm slave
`timescale 1ns/1ns
`default_nettype none
`include "tcc_regs.vh"
module tcc_indirect (
   input  wire        ref_clk_i,
   input  wire        rst_n_i,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   output reg  [1:0]  avs_response,
   input  wire [4:0]  chan_sel_i,
   output wire [7:0]  pcm_ctrl_o,
   output wire [7:0]  idle_code_o,
   output wire [7:0]  sig_ctrl_o,
   output reg         busy_o
);
   localparam ST_IDLE = 2'b00;
   localparam ST_RUN  = 2'b01;
   localparam ST_DONE = 2'b10;
   localparam RSP_OK  = 2'b00;
   localparam RSP_ERR = 2'b11;

   reg  [1:0] state_r;
   reg  [1:0] state_nxt;
   reg  [7:0] cnt_r;
   reg        pcc_en_r;
   reg        ind_en_r;
   reg  [7:0] addr_ctrl_r;
   reg  [7:0] data_buf_r;
   reg        ack_r;
   reg        busy_nxt;
   reg        pcc_en_nxt;
   reg        ind_en_nxt;
   reg  [7:0] addr_ctrl_nxt;
   reg  [7:0] data_buf_nxt;
   reg        ack_nxt;
   reg        wait_nxt;
   reg  [1:0] resp_nxt;
   reg [31:0] rdata_nxt;
   reg [31:0] rd_word;
   reg        hit_cfg;
   reg        hit_sts;
   reg        hit_adr;
   reg        hit_dat;
   reg        start;
   wire [7:0] tbl_rd;
   wire [575:0] flat;

   // byte address = offset * 4
   wire [7:0] reg_idx  = {2'b00, avs_address[7:2]};
   wire       req      = (avs_read | avs_write) & ~ack_r;
   wire       wr_lane  = avs_byteenable[0];
   wire       mapped   = hit_cfg | hit_sts | hit_adr | hit_dat;
   wire       do_wr    = req & avs_write & wr_lane;
   wire       acc_idle = state_r == ST_IDLE;
   wire [6:0] new_a    = avs_writedata[6:0];
   wire       valid_a  = new_a >= `TCC_TBL_FIRST && new_a <= `TCC_TBL_LAST;
   wire       is_rd    = addr_ctrl_r[`TCC_BIT_RNW];
   // table index 0 = internal address 01H
   wire [6:0] tbl_idx  = addr_ctrl_r[6:0] - 7'd1;
   wire       tbl_we   = (state_r == ST_DONE) & ~is_rd;
   wire       rd_land  = (state_r == ST_DONE) & is_rd;
   wire       wr_cfg   = do_wr & hit_cfg;
   wire       wr_adr   = do_wr & hit_adr & acc_idle;
   wire       wr_dat   = do_wr & hit_dat & acc_idle;

   // direct register decode
   always @* begin
      hit_cfg = 1'b0;
      hit_sts = 1'b0;
      hit_adr = 1'b0;
      hit_dat = 1'b0;
      case (reg_idx)
         `TCC_OFF_CONFIG: begin
            hit_cfg = 1'b1;
         end
         `TCC_OFF_STATUS: begin
            hit_sts = 1'b1;
         end
         `TCC_OFF_ADDR_CTRL: begin
            hit_adr = 1'b1;
         end
         `TCC_OFF_DATA_BUF: begin
            hit_dat = 1'b1;
         end
         default: begin
            hit_cfg = 1'b0;
         end
      endcase
   end

   // start refused while disabled, off the table or while an access runs
   always @* begin
      start = 1'b0;
      if (wr_adr && ind_en_r && valid_a) begin
         start = 1'b1;
      end
   end

   tcc_table u_table (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .wr_en_i   (tbl_we),
      .wr_idx_i  (tbl_idx),
      .wr_data_i (data_buf_r),
      .rd_idx_i  (tbl_idx),
      .rd_data_o (tbl_rd),
      .flat_o    (flat)
   );

   wire [4:0] chan_idx = chan_sel_i;
   tcc_chan_out u_out (
      .ref_clk_i   (ref_clk_i),
      .rst_n_i     (rst_n_i),
      .pcc_en_i    (pcc_en_r),
      .chan_i      (chan_idx),
      .flat_i      (flat),
      .pcm_ctrl_o  (pcm_ctrl_o),
      .idle_code_o (idle_code_o),
      .sig_ctrl_o  (sig_ctrl_o)
   );

   // access sequencer: a few cycles, well inside the time limit
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (cnt_r == `TCC_ACCESS_USED - 8'h01) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
         cnt_r   <= 8'h00;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_RUN) begin
            cnt_r <= cnt_r + 8'h01;
         end else begin
            cnt_r <= 8'h00;
         end
      end
   end

   // busy set by the starting write, cleared when the sequencer returns to idle
   always @* begin
      busy_nxt = busy_o;
      if (start) begin
         busy_nxt = 1'b1;
      end else if (state_r == ST_DONE) begin
         busy_nxt = 1'b0;
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= busy_nxt;
      end
   end

   // next values of the direct registers
   always @* begin
      pcc_en_nxt    = pcc_en_r;
      ind_en_nxt    = ind_en_r;
      addr_ctrl_nxt = addr_ctrl_r;
      data_buf_nxt  = data_buf_r;
      if (wr_cfg) begin
         pcc_en_nxt = avs_writedata[`TCC_BIT_PCC_EN];
         ind_en_nxt = avs_writedata[`TCC_BIT_IND_EN];
      end
      // address/control is held steady while an access runs
      if (wr_adr) begin
         addr_ctrl_nxt = avs_writedata[7:0];
      end
      // a read result at completion wins over a buffer write
      if (rd_land) begin
         data_buf_nxt = tbl_rd;
      end else if (wr_dat) begin
         data_buf_nxt = avs_writedata[7:0];
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pcc_en_r    <= 1'b0;
         ind_en_r    <= 1'b0;
         addr_ctrl_r <= `TCC_RST_BYTE;
         data_buf_r  <= `TCC_RST_BYTE;
      end else begin
         pcc_en_r    <= pcc_en_nxt;
         ind_en_r    <= ind_en_nxt;
         addr_ctrl_r <= addr_ctrl_nxt;
         data_buf_r  <= data_buf_nxt;
      end
   end

   // read word for the direct registers, upper bits always zero
   always @* begin
      rd_word = 32'h00000000;
      case (reg_idx)
         `TCC_OFF_CONFIG: begin
            rd_word[`TCC_BIT_IND_EN] = ind_en_r;
            rd_word[`TCC_BIT_PCC_EN] = pcc_en_r;
         end
         `TCC_OFF_STATUS: begin
            rd_word[`TCC_BIT_BUSY] = busy_o;
         end
         `TCC_OFF_ADDR_CTRL: begin
            rd_word[7:0] = addr_ctrl_r;
         end
         `TCC_OFF_DATA_BUF: begin
            rd_word[7:0] = data_buf_r;
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   // one wait cycle, then acknowledge for a single cycle
   always @* begin
      ack_nxt   = 1'b0;
      wait_nxt  = 1'b1;
      resp_nxt  = RSP_OK;
      rdata_nxt = avs_readdata;
      if (req) begin
         ack_nxt  = 1'b1;
         wait_nxt = 1'b0;
         if (!mapped) begin
            resp_nxt = RSP_ERR;
         end
         if (avs_read) begin
            rdata_nxt = rd_word;
         end
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ack_r           <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
         avs_response    <= RSP_OK;
      end else begin
         ack_r           <= ack_nxt;
         avs_waitrequest <= wait_nxt;
         avs_readdata    <= rdata_nxt;
         avs_response    <= resp_nxt;
      end
   end
endmodule
`default_nettype wire

// *** tb/tcc_indirect_sva.sv ***
// assertion checker for the indirect access port
`timescale 1ns/1ns
`default_nettype none
module tcc_indirect_sva (
   input wire logic        ref_clk_i,
   input wire logic        rst_n_i,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [4:0]  chan_sel_i,
   input wire logic [7:0]  pcm_ctrl_o,
   input wire logic [7:0]  idle_code_o,
   input wire logic [7:0]  sig_ctrl_o,
   input wire logic        busy_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_start; $rose(busy_o) |-> avs_write && !avs_waitrequest && avs_address == 8'hC8; endproperty
   a_start: assert property (p_start) else $error("busy rose without a start");
   property p_done; $rose(busy_o) |-> ##[1:80] !busy_o; endproperty
   a_done: assert property (p_done) else $error("access too long");
   property p_held; $rose(busy_o) |=> busy_o; endproperty
   a_held: assert property (p_held) else $error("busy pulse too short");
   property p_stat; avs_read && !avs_waitrequest && avs_address == 8'hC4
      |-> avs_readdata[7] == $past(busy_o); endproperty
   a_stat: assert property (p_stat) else $error("status busy bit wrong");
   property p_range; $past(chan_sel_i) > 5'h17 |-> (pcm_ctrl_o | idle_code_o | sig_ctrl_o) == 8'h00;
   endproperty
   a_range: assert property (p_range) else $error("bytes for missing channel");
   property p_bad; avs_write && !avs_waitrequest && avs_address == 8'hC8 && !$past(busy_o)
      && (avs_writedata[6:0] == 7'h00 || avs_writedata[6:0] > 7'h48) |-> !busy_o; endproperty
   a_bad: assert property (p_bad) else $error("start on bad address");
   property p_ack; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_ack: assert property (p_ack) else $error("ack longer than one cycle");
   property p_quiet; !$past(busy_o) && !busy_o && !avs_write |=> !busy_o; endproperty
   a_quiet: assert property (p_quiet) else $error("busy rose without write");
endmodule
bind tcc_indirect tcc_indirect_sva i_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .chan_sel_i(chan_sel_i), .pcm_ctrl_o(pcm_ctrl_o),
   .idle_code_o(idle_code_o), .sig_ctrl_o(sig_ctrl_o), .busy_o(busy_o));
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the indirect access port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        ref_clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [4:0]  chan_sel_i = 5'h00;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire  [1:0]  avs_response;
   wire  [7:0]  pcm, idle, sig;
   wire         busy_o;
   int          n_errors = 0;
   int          num_checks = 0;
   logic [7:0]  q;
   logic [1:0]  rsp;
   always #4 ref_clk_i = ~ref_clk_i;
   tcc_indirect i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .chan_sel_i(chan_sel_i), .pcm_ctrl_o(pcm),
      .idle_code_o(idle), .sig_ctrl_o(sig), .busy_o(busy_o));
   task conclude;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin
         n_errors++;
         conclude();
      end
      q = avs_readdata[7:0];
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task poll;
      int p;
      p = 0;
      acc(1'b0, 8'hC4, 8'h00);
      chk(q & 8'h80, 8'h80);
      while (q[7] !== 1'b0 && p < 30) begin
         acc(1'b0, 8'hC4, 8'h00);
         p++;
      end
      chk(q & 8'h80, 8'h00);
      if (p >= 30) conclude();
   endtask
   task outs(input logic [4:0] c, input logic [7:0] p, input logic [7:0] i, input logic [7:0] s);
      chan_sel_i <= c;
      repeat (2) @(posedge ref_clk_i);
      chk(pcm, p);
      chk(idle, i);
      chk(sig, s);
   endtask
   initial begin
      logic [7:0] a;
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 8'hC0 + 8'(4 * i), 8'h00);
         chk(q, 8'h00);
      end
      acc(1'b0, 8'hD0, 8'h00);
      chk({6'h0, rsp}, 8'h03);
      acc(1'b1, 8'hC8, 8'h05);
      acc(1'b0, 8'hC4, 8'h00);
      chk(q & 8'h80, 8'h00);
      acc(1'b1, 8'hC0, 8'h03);
      acc(1'b0, 8'hC0, 8'h00);
      chk(q, 8'h03);
      acc(1'b1, 8'hC8, 8'h49);
      acc(1'b0, 8'hC4, 8'h00);
      chk(q & 8'h80, 8'h00);
      for (int k = 0; k < 6; k++) begin
         a = 8'(1 + 24 * (k % 3) + 23 * (k / 3));
         acc(1'b1, 8'hCC, a ^ 8'hA5);
         acc(1'b1, 8'hC8, a);
         poll();
      end
      for (int k = 0; k < 6; k++) begin
         a = 8'(1 + 24 * (k % 3) + 23 * (k / 3));
         acc(1'b1, 8'hC8, 8'h80 | a);
         poll();
         acc(1'b0, 8'hCC, 8'h00);
         chk(q, a ^ 8'hA5);
      end
      outs(5'h00, 8'h01 ^ 8'hA5, 8'h19 ^ 8'hA5, 8'h31 ^ 8'hA5);
      outs(5'h17, 8'h18 ^ 8'hA5, 8'h30 ^ 8'hA5, 8'h48 ^ 8'hA5);
      outs(5'h18, 8'h00, 8'h00, 8'h00);
      acc(1'b1, 8'hC0, 8'h02);
      outs(5'h00, 8'h00, 8'h00, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
